// ### rtl/cpi_fifo.sv
// flip-flop fifo for the write payload words
`timescale 1ns/1ps
module cpi_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i, // system clock
	input wire logic srst_i, // synchronous reset, high
	cpi_fifo_if.fifo_side f // push and pop sides
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	// ----------------------------------------------------------------
	// status and handshakes
	// ----------------------------------------------------------------
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire do_push = f.push_valid && !full;
	wire do_pop = f.pop_ready && !empty;

	assign f.push_ready = !full;
	assign f.pop_valid = !empty;
	assign f.pop_data = mem[rd_ptr[AW-1:0]];

	// storage, written at the tail
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= f.push_data;
		end
	end

	// pointers with wrap bit
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// ### rtl/cpi_host.sv
// host that drives configuration packets into the byte-wide configuration port
//
// Overview of operation
// - stream is framed in 32-bit words
// - opcode read is 01, write is 10
// - header word first, then payload words
// - standard header carries type 001 plus fields
// - header count 0..2047 gives payload length
// - larger counts use zero count plus extension
// - extension: type 010, same opcode, 20-bit count
// - words go over parallel port in order
// - pads then sync word before any packet
// - after sync: reset CRC, length, option, mask
// - readback: address, command, count, pad, read
`timescale 1ns/1ps
`include "cpi_regs.svh"
module cpi_host
	import cpi_pkg::*;
(
	input wire logic MCLK_I, // 100 MHz clock
	input wire logic SRST_I, // synchronous reset, high
	input wire logic CMD_VALID_I, // command request
	output logic CMD_READY_O, // idle, command taken
	input wire logic [1:0] CMD_KIND_I, // init, write, read, readback
	input wire logic [3:0] CMD_ADDR_I, // target register
	input wire logic [19:0] CMD_COUNT_I, // payload words
	input wire logic [31:0] CMD_FRAME_ADDR_I, // start frame address
	input wire logic [31:0] CMD_FRAME_LEN_I, // frame length value
	input wire logic [31:0] CMD_OPTION_I, // option value
	input wire logic [31:0] CMD_MASK_I, // mask value
	input wire logic WR_VALID_I, // payload word offered
	input wire logic [31:0] WR_DATA_I, // payload word
	output logic WR_READY_O, // buffer has room
	output logic RD_VALID_O, // read word pulse
	output logic [31:0] RD_DATA_O, // read word
	output logic DONE_O, // command finished pulse
	output logic CFG_CS_N_O, // port select, low
	output logic CFG_WR_N_O, // port write, low
	output logic [7:0] CFG_D_O, // data byte out
	output logic CFG_D_OE_O, // data byte driven
	input wire logic [7:0] CFG_D_I, // data byte in
	input wire logic CFG_BUSY_I // device stall
);
	// ----------------------------------------------------------------
	// header builders
	// ----------------------------------------------------------------
	function automatic cpi_word_t mk_hdr(input cpi_op_t op, input logic [3:0] addr,
		input logic [10:0] cnt);
		mk_hdr = {`CPI_TYPE_STD, op, 10'h000, addr, 2'b00, cnt};
	endfunction

	function automatic cpi_word_t mk_ext(input cpi_op_t op, input logic [19:0] cnt);
		mk_ext = {`CPI_TYPE_EXT, op, 7'h00, cnt};
	endfunction

	// count field of a standard header, zero when an extension follows
	function automatic logic [10:0] hdr_cnt(input logic big, input logic [19:0] cnt);
		hdr_cnt = big ? 11'h000 : cnt[10:0];
	endfunction

	// number of fixed words sent ahead of the body
	function automatic logic [4:0] pre_len(input cpi_cmd_e k, input logic big);
		case (k)
			CPI_INIT: pre_len = `CPI_PAD_WORDS + `CPI_INIT_TAIL;
			CPI_WRITE, CPI_READ: pre_len = big ? 5'd2 : 5'd1;
			CPI_READBACK: pre_len = big ? 5'd7 : 5'd6;
			default: pre_len = 5'd0;
		endcase
	endfunction

	// fixed word of the preamble at position i
	function automatic cpi_word_t pre_word(input cpi_cmd_e k, input logic [4:0] i,
		input logic big, input logic [3:0] addr, input logic [19:0] cnt,
		input cpi_word_t frame_addr, input cpi_word_t frame_len, input cpi_word_t option,
		input cpi_word_t msk);
		logic [4:0] j;
		j = i - `CPI_PAD_WORDS;
		pre_word = `CPI_PAD_WORD;
		case (k)
			CPI_INIT: begin
				if (i < `CPI_PAD_WORDS) begin
					pre_word = `CPI_PAD_WORD;
				end else begin
					case (j)
						5'd0: pre_word = `CPI_SYNC_WORD;
						5'd1: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_CMD, 11'h001);
						5'd2: pre_word = `CPI_CODE_RCRC;
						5'd3: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_FRAME_LEN, 11'h001);
						5'd4: pre_word = frame_len;
						5'd5: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_OPTION, 11'h001);
						5'd6: pre_word = option;
						5'd7: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_MASK, 11'h001);
						5'd8: pre_word = msk;
						default: pre_word = `CPI_PAD_WORD;
					endcase
				end
			end
			CPI_WRITE: begin
				if (i == 5'd0) begin
					pre_word = mk_hdr(`CPI_OP_WRITE, addr, hdr_cnt(big, cnt));
				end else begin
					pre_word = mk_ext(`CPI_OP_WRITE, cnt);
				end
			end
			CPI_READ: begin
				if (i == 5'd0) begin
					pre_word = mk_hdr(`CPI_OP_READ, addr, hdr_cnt(big, cnt));
				end else begin
					pre_word = mk_ext(`CPI_OP_READ, cnt);
				end
			end
			CPI_READBACK: begin
				case (i)
					5'd0: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_FRAME_ADDR, 11'h001);
					5'd1: pre_word = frame_addr;
					5'd2: pre_word = mk_hdr(`CPI_OP_WRITE, `CPI_REG_CMD, 11'h001);
					5'd3: pre_word = `CPI_CODE_READ_FRAMES;
					5'd4: pre_word = mk_hdr(`CPI_OP_READ, `CPI_REG_FRAME_OUT, hdr_cnt(big, cnt));
					5'd5: pre_word = big ? mk_ext(`CPI_OP_READ, cnt) : `CPI_PAD_WORD;
					default: pre_word = `CPI_PAD_WORD;
				endcase
			end
			default: pre_word = `CPI_PAD_WORD;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cpi_state_e state;
	cpi_cmd_e kind;
	logic [3:0] addr;
	logic [19:0] count;
	logic [19:0] left;
	logic big;
	cpi_word_t frame_addr_val;
	cpi_word_t frame_len_val;
	cpi_word_t option_val;
	cpi_word_t mask_val;
	logic [4:0] idx;
	logic [1:0] byte_cnt;
	cpi_word_t shift;
	logic [23:0] rd_sh;

	// ----------------------------------------------------------------
	// write data buffer
	// ----------------------------------------------------------------
	cpi_fifo_if #(.WIDTH(`CPI_FIFO_WIDTH)) wbuf ();

	cpi_fifo #(
		.WIDTH(`CPI_FIFO_WIDTH),
		.DEPTH(`CPI_FIFO_DEPTH)
	) u_wbuf (
		.clk_i(MCLK_I),
		.srst_i(SRST_I),
		.f(wbuf.fifo_side)
	);

	// user side of the buffer
	assign wbuf.push_valid = WR_VALID_I;
	assign wbuf.push_data = WR_DATA_I;
	assign WR_READY_O = wbuf.push_ready;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire cmd_take = CMD_VALID_I && (state == ST_IDLE);
	wire in_big = CMD_COUNT_I > `CPI_HDR_CNT_MAX;
	wire cpi_cmd_e in_kind = cpi_cmd_e'(CMD_KIND_I);
	wire pre_active = idx < pre_len(kind, big);
	wire cpi_word_t pre_data = pre_word(kind, idx, big, addr, count, frame_addr_val,
		frame_len_val, option_val, mask_val);
	wire body_write = (kind == CPI_WRITE);
	wire body_read = (kind == CPI_READ) || (kind == CPI_READBACK);
	wire body_more = (left != 20'h00000);
	wire load_fifo = (state == ST_LOAD) && !pre_active && body_write && body_more;
	wire byte_ok = !CFG_BUSY_I;
	wire last_byte = (byte_cnt == 2'd3);

	assign wbuf.pop_ready = load_fifo; // engine stalls on empty buffer
	assign CMD_READY_O = (state == ST_IDLE);

	// port strobes: write while shifting, read with data released
	assign CFG_CS_N_O = !((state == ST_SHIFT) || (state == ST_READ));
	assign CFG_WR_N_O = !(state == ST_SHIFT);
	assign CFG_D_OE_O = (state == ST_SHIFT);
	assign CFG_D_O = shift[31:24]; // most significant byte first

	// ----------------------------------------------------------------
	// command capture
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			kind <= CPI_INIT;
			addr <= 4'h0;
			count <= 20'h00000;
			big <= 1'b0;
			frame_addr_val <= 32'h0000_0000;
			frame_len_val <= 32'h0000_0000;
			option_val <= 32'h0000_0000;
			mask_val <= 32'h0000_0000;
		end else if (cmd_take) begin
			kind <= in_kind;
			addr <= CMD_ADDR_I;
			count <= CMD_COUNT_I;
			big <= in_big && (in_kind != CPI_INIT);
			frame_addr_val <= CMD_FRAME_ADDR_I;
			frame_len_val <= CMD_FRAME_LEN_I;
			option_val <= CMD_OPTION_I;
			mask_val <= CMD_MASK_I;
		end
	end

	// ----------------------------------------------------------------
	// word sequencer and byte engine
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			state <= ST_IDLE;
			left <= 20'h00000;
			idx <= 5'd0;
			byte_cnt <= 2'd0;
			shift <= 32'h0000_0000;
			rd_sh <= 24'h000000;
			RD_DATA_O <= 32'h0000_0000;
			RD_VALID_O <= 1'b0;
			DONE_O <= 1'b0;
		end else begin
			RD_VALID_O <= 1'b0;
			DONE_O <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cmd_take) begin
						idx <= 5'd0;
						byte_cnt <= 2'd0;
						left <= (in_kind == CPI_INIT) ? 20'h00000 : CMD_COUNT_I;
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (pre_active) begin
						shift <= pre_data;
						idx <= idx + 5'd1;
						state <= ST_SHIFT;
					end else if (body_write && body_more) begin
						if (wbuf.pop_valid) begin
							shift <= wbuf.pop_data;
							left <= left - 20'h00001;
							state <= ST_SHIFT;
						end
					end else if (body_read && body_more) begin
						state <= ST_TURN; // release the data bus first
					end else begin
						DONE_O <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_SHIFT: begin
					if (byte_ok) begin
						byte_cnt <= byte_cnt + 2'd1;
						shift <= {shift[23:0], 8'h00};
						if (last_byte) begin
							state <= ST_LOAD;
						end
					end
				end
				ST_TURN: begin
					byte_cnt <= 2'd0;
					state <= ST_READ;
				end
				ST_READ: begin
					if (byte_ok) begin
						byte_cnt <= byte_cnt + 2'd1;
						rd_sh <= {rd_sh[15:0], CFG_D_I};
						if (last_byte) begin
							RD_DATA_O <= {rd_sh, CFG_D_I};
							RD_VALID_O <= 1'b1;
							left <= left - 20'h00001;
							if (left == 20'h00001) begin
								DONE_O <= 1'b1;
								state <= ST_IDLE;
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ### shared/cpi_fifo_if.sv
// valid/ready signals on both sides of the write data buffer
`timescale 1ns/1ps
interface cpi_fifo_if #(parameter int WIDTH = 32);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport fifo_side (
		input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data
	);
	modport user_side (
		output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data
	);
endinterface

// ### shared/cpi_pkg.sv
// types of the configuration packet host
package cpi_pkg;
	typedef enum logic [1:0] {
		CPI_INIT = 2'b00,
		CPI_WRITE = 2'b01,
		CPI_READ = 2'b10,
		CPI_READBACK = 2'b11
	} cpi_cmd_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_SHIFT = 3'b010,
		ST_TURN = 3'b011,
		ST_READ = 3'b100
	} cpi_state_e;

	typedef logic [31:0] cpi_word_t;
	typedef logic [1:0] cpi_op_t;
endpackage

// ### shared/cpi_regs.svh
// constants of the configuration packet host: codes, addresses, sequence figures
`ifndef CPI_REGS_SVH
`define CPI_REGS_SVH

// ----------------------------------------------------------------
// packet header fields
// ----------------------------------------------------------------
`define CPI_OP_READ 2'b01
`define CPI_OP_WRITE 2'b10
`define CPI_TYPE_STD 3'b001
`define CPI_TYPE_EXT 3'b010
`define CPI_HDR_CNT_MAX 20'h007ff

// ----------------------------------------------------------------
// device configuration register addresses
// ----------------------------------------------------------------
`define CPI_REG_CRC 4'h0
`define CPI_REG_FRAME_ADDR 4'h1
`define CPI_REG_FDRI 4'h2
`define CPI_REG_FRAME_OUT 4'h3
`define CPI_REG_CMD 4'h4
`define CPI_REG_CTL 4'h5
`define CPI_REG_MASK 4'h6
`define CPI_REG_STAT 4'h7
`define CPI_REG_LOUT 4'h8
`define CPI_REG_OPTION 4'h9
`define CPI_REG_FRAME_LEN 4'hb

// ----------------------------------------------------------------
// command register codes
// ----------------------------------------------------------------
`define CPI_CODE_READ_FRAMES 32'h0000_0004
`define CPI_CODE_RCRC 32'h0000_0007

// ----------------------------------------------------------------
// stream framing words and preamble figures
// ----------------------------------------------------------------
`define CPI_PAD_WORD 32'hffff_ffff
`define CPI_SYNC_WORD 32'h5a3c_c3a5
`define CPI_PAD_WORDS 5'd2
`define CPI_INIT_TAIL 5'd9

// ----------------------------------------------------------------
// write data buffer
// ----------------------------------------------------------------
`define CPI_FIFO_WIDTH 32
`define CPI_FIFO_DEPTH 8

`endif

// ### testbench/cpi_dev_model.sv
// behavioural device behind the byte-wide configuration port
`timescale 1ns/1ps
`include "cpi_regs.svh"
module cpi_dev_model
	import cpi_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic srst_i, // reset
	input wire logic cs_n_i, // select
	input wire logic wr_n_i, // strobe
	input wire logic [7:0] d_i, // bus level
	input wire logic slow_i, // stall often
	output logic [7:0] d_o, // byte to host
	output logic busy_o // stall
);
	// ----------------------------------------
	// packet decoder and register file
	// ----------------------------------------
	cpi_word_t regs [16];
	cpi_word_t sh = 32'h0;
	cpi_word_t rw = 32'h0;
	cpi_word_t wlog[$];
	cpi_word_t rq[$];
	logic [3:0] tlog[$];
	logic [3:0] tgt = 4'h0;
	cpi_op_t op = 2'h0;
	logic synced = 1'b0;
	logic ext_ok = 1'b0;
	logic [7:0] last = 8'h00;
	int nb = 0, rb = 0, left = 0, pads = 0, errs = 0, ext_cnt = 0;
	// released or stalled bus shows the inverse of the last byte
	assign d_o = (!cs_n_i && wr_n_i && !busy_o) ? rw[31-8*rb -: 8] : ~last;
	// queue read words for a read packet
	task automatic fill();
		if (op == `CPI_OP_READ) begin
			for (int k = 0; k < left; k++)
				rq.push_back((tgt == `CPI_REG_FRAME_OUT ?
					regs[`CPI_REG_FRAME_ADDR] : regs[tgt]) + k);
			left = 0;
		end
	endtask
	// act on one whole word
	task automatic take_word(input cpi_word_t w);
		if (!synced) begin
			synced = (w === `CPI_SYNC_WORD);
			pads += (w === `CPI_PAD_WORD);
		end else if (left > 0) begin
			regs[tgt] = w;
			wlog.push_back(w);
			left--;
		end else if (w[31:29] == `CPI_TYPE_STD) begin
			op = w[28:27];
			tgt = w[16:13];
			left = w[10:0];
			ext_ok = (w[10:0] == 11'h000);
			if (op == `CPI_OP_WRITE)
				tlog.push_back(tgt);
			else if (op != `CPI_OP_READ)
				errs++;
			fill();
		end else if (w[31:29] == `CPI_TYPE_EXT && ext_ok && w[28:27] == op) begin
			left = w[19:0];
			ext_cnt = left;
			ext_ok = 1'b0;
			fill();
		end else if (w !== `CPI_PAD_WORD)
			errs++;
	endtask
	// byte transfers, four to a word, most significant first
	always @(posedge clk_i) begin
		if (srst_i) begin
			synced = 1'b0;
			nb = 0;
			left = 0;
			rq.delete();
			rb <= 0;
			busy_o <= 1'b0;
		end else begin
			busy_o <= slow_i && !busy_o;
			if (!cs_n_i && !busy_o && !wr_n_i) begin
				sh = {sh[23:0], d_i};
				nb++;
				if (nb == 4) begin
					nb = 0;
					take_word(sh);
				end
			end
			if (!cs_n_i && !busy_o && wr_n_i) begin
				last <= d_o;
				rb <= (rb + 1) % 4;
				if (rb == 3)
					void'(rq.pop_front());
			end
		end
		rw <= rq.size() > 0 ? rq[0] : ~rw;
	end
endmodule

// ### testbench/cpi_host_props.sv
// port assertions for the configuration packet host
`timescale 1ns/1ps
module cpi_host_props (
	input wire logic MCLK_I, // clock
	input wire logic SRST_I, // reset
	input wire logic CMD_VALID_I, // request
	input wire logic CMD_READY_O, // idle
	input wire logic [1:0] CMD_KIND_I, // kind
	input wire logic RD_VALID_O, // read pulse
	input wire logic DONE_O, // done pulse
	input wire logic CFG_CS_N_O, // select
	input wire logic CFG_WR_N_O, // strobe
	input wire logic [7:0] CFG_D_O, // byte out
	input wire logic CFG_D_OE_O, // byte driven
	input wire logic CFG_BUSY_I // stall
);
	// ----------------------------------------
	// relations between the ports
	// ----------------------------------------
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SRST_I);
	// decoded port cycles
	wire take = CMD_VALID_I && CMD_READY_O;
	wire wr_cyc = !CFG_CS_N_O && !CFG_WR_N_O;
	wire rd_cyc = !CFG_CS_N_O && CFG_WR_N_O;
	a_reset_idle: assert property ($fell(SRST_I) |-> CMD_READY_O && CFG_CS_N_O
		&& !CFG_D_OE_O && !DONE_O) else $error("outputs not idle after reset");
	a_take_busy: assert property (take |=> !CMD_READY_O)
		else $error("ready stayed high after a take");
	a_done_once: assert property (DONE_O |-> CMD_READY_O ##1 !DONE_O)
		else $error("done not a single cycle in idle");
	a_idle_quiet: assert property (CMD_READY_O |-> CFG_CS_N_O)
		else $error("port selected while idle");
	a_byte_hold: assert property (wr_cyc && CFG_BUSY_I |=> wr_cyc && $stable(CFG_D_O))
		else $error("byte changed during a stall");
	a_drive_write: assert property (wr_cyc |-> CFG_D_OE_O)
		else $error("write byte not driven");
	a_release_read: assert property (rd_cyc |-> !CFG_D_OE_O)
		else $error("bus driven during a read");
	a_turn_gap: assert property (rd_cyc && !$past(rd_cyc) |-> $past(CFG_CS_N_O))
		else $error("read began without an idle cycle");
	a_pad_first: assert property (take && CMD_KIND_I == 2'h0 |-> ##[2:6]
		(wr_cyc && CFG_D_O == 8'hff)) else $error("init did not open with a pad byte");
	a_rd_pulse: assert property (RD_VALID_O |=> !RD_VALID_O)
		else $error("read pulse longer than a cycle");
	// main scenarios reached
	c_readback: cover property (take && CMD_KIND_I == 2'h3);
	c_last_read: cover property (RD_VALID_O && DONE_O);
	c_stall: cover property (wr_cyc && CFG_BUSY_I);
endmodule
bind cpi_host cpi_host_props u_props (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
	.CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .CMD_KIND_I(CMD_KIND_I),
	.RD_VALID_O(RD_VALID_O), .DONE_O(DONE_O), .CFG_CS_N_O(CFG_CS_N_O),
	.CFG_WR_N_O(CFG_WR_N_O), .CFG_D_O(CFG_D_O), .CFG_D_OE_O(CFG_D_OE_O),
	.CFG_BUSY_I(CFG_BUSY_I));

// ### testbench/tb_cpi_host.sv
// self-checking bench for the configuration packet host
`timescale 1ns/1ps
`include "cpi_regs.svh"
module tb_cpi_host import cpi_pkg::*;;
	logic MCLK_I = 1'b0;
	logic SRST_I = 1'b1;
	logic CMD_VALID_I = 1'b0;
	logic WR_VALID_I = 1'b0;
	logic slow = 1'b0;
	logic [1:0] CMD_KIND_I = 2'h0;
	logic [3:0] CMD_ADDR_I = 4'h0;
	logic [19:0] CMD_COUNT_I = 20'h0;
	cpi_word_t CMD_FRAME_ADDR_I = 32'h0, CMD_FRAME_LEN_I = 32'h0, CMD_OPTION_I = 32'h0;
	cpi_word_t CMD_MASK_I = 32'h0, WR_DATA_I = 32'h0, RD_DATA_O;
	logic CMD_READY_O, WR_READY_O, RD_VALID_O, DONE_O, CFG_CS_N_O, CFG_WR_N_O;
	logic CFG_D_OE_O, CFG_BUSY_I;
	logic [7:0] CFG_D_O, dev_d;
	cpi_word_t rd_q[$];
	int fail_count = 0, total_checks = 0;
	// bus level from both drivers
	wire [7:0] CFG_D_I = CFG_D_OE_O ? CFG_D_O : dev_d;
	always #5 MCLK_I = ~MCLK_I;
	cpi_host dut (.MCLK_I(MCLK_I), .SRST_I(SRST_I), .CMD_VALID_I(CMD_VALID_I),
		.CMD_READY_O(CMD_READY_O), .CMD_KIND_I(CMD_KIND_I), .CMD_ADDR_I(CMD_ADDR_I),
		.CMD_COUNT_I(CMD_COUNT_I), .CMD_FRAME_ADDR_I(CMD_FRAME_ADDR_I),
		.CMD_FRAME_LEN_I(CMD_FRAME_LEN_I), .CMD_OPTION_I(CMD_OPTION_I),
		.CMD_MASK_I(CMD_MASK_I), .WR_VALID_I(WR_VALID_I),
		.WR_DATA_I(WR_DATA_I), .WR_READY_O(WR_READY_O), .RD_VALID_O(RD_VALID_O),
		.RD_DATA_O(RD_DATA_O), .DONE_O(DONE_O), .CFG_CS_N_O(CFG_CS_N_O),
		.CFG_WR_N_O(CFG_WR_N_O), .CFG_D_O(CFG_D_O), .CFG_D_OE_O(CFG_D_OE_O),
		.CFG_D_I(CFG_D_I), .CFG_BUSY_I(CFG_BUSY_I));
	cpi_dev_model dev (.clk_i(MCLK_I), .srst_i(SRST_I), .cs_n_i(CFG_CS_N_O),
		.wr_n_i(CFG_WR_N_O), .d_i(CFG_D_I), .slow_i(slow), .d_o(dev_d), .busy_o(CFG_BUSY_I));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input cpi_word_t seen, input cpi_word_t exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_q(input cpi_word_t q[$], input cpi_word_t base, input int n);
		chk(q.size(), n);
		for (int k = 0; k < n; k++)
			chk(q[k], base + k);
	endtask
	task automatic close_out();
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// offer payload words, each held until the buffer takes it
	task automatic push_n(input cpi_word_t base, input int n);
		logic ok;
		for (int k = 0; k < n; k++) begin
			WR_VALID_I = 1'b1;
			WR_DATA_I = base + k;
			do begin
				ok = WR_READY_O;
				@(posedge MCLK_I);
				#1;
			end while (!ok);
		end
		WR_VALID_I = 1'b0;
	endtask
	// issue one command, gather read words until done
	task automatic run(input logic [1:0] kind, input logic [3:0] addr, input logic [19:0] n);
		logic ok;
		rd_q.delete();
		dev.wlog.delete();
		CMD_VALID_I = 1'b1;
		CMD_KIND_I = kind;
		CMD_ADDR_I = addr;
		CMD_COUNT_I = n;
		do begin
			ok = CMD_READY_O;
			@(posedge MCLK_I);
			#1;
		end while (!ok);
		CMD_VALID_I = 1'b0;
		for (int i = 0; i < 30000; i++) begin
			if (RD_VALID_O === 1'b1)
				rd_q.push_back(RD_DATA_O);
			if (DONE_O === 1'b1)
				return;
			@(posedge MCLK_I);
			#1;
		end
		chk(DONE_O, 1'b1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_init();
		logic [3:0] order [4] = '{`CPI_REG_CMD, `CPI_REG_FRAME_LEN, `CPI_REG_OPTION,
			`CPI_REG_MASK};
		slow = 1'b1;
		CMD_FRAME_LEN_I = 32'h0000_0015;
		CMD_OPTION_I = 32'h0000_3fe5;
		CMD_MASK_I = 32'h0000_0c00;
		run(2'h0, 4'h0, 20'h0);
		chk(dev.synced, 1'b1);
		chk(dev.pads, `CPI_PAD_WORDS);
		for (int i = 0; i < 4; i++)
			chk(dev.tlog[i], order[i]);
		chk(dev.regs[`CPI_REG_CMD], `CPI_CODE_RCRC);
		chk(dev.regs[`CPI_REG_FRAME_LEN], 32'h0000_0015);
		chk(dev.regs[`CPI_REG_OPTION], 32'h0000_3fe5);
		chk(dev.regs[`CPI_REG_MASK], 32'h0000_0c00);
	endtask
	task automatic t_fill();
		push_n(32'h1100_0000, 8);
		@(posedge MCLK_I);
		#1;
		chk(WR_READY_O, 1'b0);
		WR_VALID_I = 1'b1;
		WR_DATA_I = 32'hdead_0bad;
		repeat (3) @(posedge MCLK_I);
		#1;
		WR_VALID_I = 1'b0;
		run(2'h1, `CPI_REG_FDRI, 20'h8);
		chk_q(dev.wlog, 32'h1100_0000, 8);
		chk(WR_READY_O, 1'b1);
		chk(dev.op, `CPI_OP_WRITE);
		chk(dev.tlog[dev.tlog.size()-1], `CPI_REG_FDRI);
	endtask
	task automatic t_big();
		slow = 1'b0;
		fork
			push_n(32'h2200_0000, 2048);
			run(2'h1, `CPI_REG_FDRI, 20'h00800);
		join
		chk(dev.ext_cnt, 2048);
		chk_q(dev.wlog, 32'h2200_0000, 2048);
	endtask
	task automatic t_read();
		slow = 1'b1;
		run(2'h1, `CPI_REG_CTL, 20'h0);
		chk(dev.wlog.size(), 0);
		run(2'h2, `CPI_REG_OPTION, 20'h2);
		chk(dev.op, `CPI_OP_READ);
		chk_q(rd_q, 32'h0000_3fe5, 2);
		CMD_FRAME_ADDR_I = 32'h0012_3400;
		run(2'h3, 4'h0, 20'h3);
		chk_q(rd_q, 32'h0012_3400, 3);
		chk(dev.regs[`CPI_REG_FRAME_ADDR], 32'h0012_3400);
		chk(dev.regs[`CPI_REG_CMD], `CPI_CODE_READ_FRAMES);
		// large read packet: zero count header plus extension
		slow = 1'b0;
		run(2'h2, `CPI_REG_MASK, 20'h00801);
		chk(dev.ext_cnt, 2049);
		chk_q(rd_q, 32'h0000_0c00, 2049);
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge MCLK_I);
		#1;
		SRST_I = 1'b0;
		t_init();
		t_fill();
		t_big();
		t_read();
		chk(dev.errs, 0);
		close_out();
	end
	// watchdog against a hang
	initial begin
		#600000;
		fail_count++;
		close_out();
	end
endmodule
